// ### rtl/rtpio_pkg.sv
// shared types and constants of the remote ttl process i/o block
package rtpio_pkg;

  // clock and input debounce timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DEBOUNCE_NS = 20000;
  localparam int unsigned DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // channel counts
  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned NUM_REMOTE = 12;

  // register byte offsets
  localparam logic [7:0] REG_CHAN_CTRL = 8'h00;
  localparam logic [7:0] REG_PROC_IN = 8'h04;
  localparam logic [7:0] REG_REMOTE_IN = 8'h08;
  localparam logic [7:0] REG_CMD_STATE = 8'h0c;

  // reset values
  localparam logic [7:0] CHAN_CTRL_RST = 8'h00;
  localparam logic PIN_IDLE_RST = 1'b1;
  localparam logic PIRANI_ON_RST = 1'b1;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // remote control ttl inputs, all active low except remote_ignore
  typedef struct packed {
    logic gauge_a_emit_req_n;
    logic gauge_b_emit_req_n;
    logic bakeout_req_n;
    logic emission_inhibit_n;
    logic gauge_keys_lock_n;
    logic pirani_a_shutdown_n;
    logic pirani_b_shutdown_n;
    logic log_erase_n;
    logic remote_ignore;
    logic filament_a_select_n;
    logic filament_b_select_n;
    logic panel_lock_n;
  } rtpio_remote_type;

  // commands handed to the gauge logic, active high
  typedef struct packed {
    logic gauge_a_emit;
    logic gauge_b_emit;
    logic degas;
    logic pirani_a_on;
    logic pirani_b_on;
    logic filament_a_sel;
    logic filament_b_sel;
    logic log_clear;
    logic gauge_keys_lock;
    logic panel_lock;
  } rtpio_cmd_type;

endpackage : rtpio_pkg

// ### rtl/rtpio_top.sv
// remote ttl process i/o port with axi4-lite register slave
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps

// two-flop synchroniser followed by a stability counter
module rtpio_debounce #(
  parameter int unsigned CYCLES = rtpio_pkg::DEBOUNCE_CYCLES,
  parameter logic IDLE = rtpio_pkg::PIN_IDLE_RST
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic raw_i,
  output logic level_o
);
  import rtpio_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic meta;
    logic sync;
    logic [CW-1:0] cnt;
    logic level;
  } rtpio_deb_state_type;

  rtpio_deb_state_type state_q;
  rtpio_deb_state_type state_d;

  // level only moves after the synced input held a new value for CYCLES clocks
  always_comb begin
    state_d = state_q;
    state_d.meta = raw_i;
    state_d.sync = state_q.meta; // meta is read here only
    if (state_q.sync == state_q.level) begin
      state_d.cnt = '0;
    end else if (state_q.cnt == CNT_LAST) begin
      state_d.level = state_q.sync;
      state_d.cnt = '0;
    end else begin
      state_d.cnt = state_q.cnt + CW'(1);
    end
  end

  // reset to the pin's released level, so no false edge follows reset
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= '{meta: IDLE, sync: IDLE, cnt: '0, level: IDLE};
    end else begin
      state_q <= state_d;
    end
  end

  assign level_o = state_q.level;

endmodule : rtpio_debounce

module rtpio_top #(
  parameter int unsigned DEB_CYCLES = rtpio_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clock_i,
  input wire logic rst_i,
  // remote control and process ttl pins
  input rtpio_pkg::rtpio_remote_type remote_i,
  input wire logic [7:0] proc_in_n_i,
  output logic [7:0] proc_out_n_o,
  output logic [7:0] relay_active_o,
  output rtpio_pkg::rtpio_cmd_type cmd_o,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rtpio_pkg::*;

  localparam int unsigned NUM_IN = NUM_REMOTE + NUM_CHAN;

  typedef struct packed {
    rtpio_remote_type prev;
    logic emit_a_req;
    logic emit_b_req;
    rtpio_cmd_type cmd;
    logic [7:0] chan_active;
    logic [7:0] out_n;
    logic [7:0] relay;
    logic [7:0] aw_addr;
    logic aw_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic w_held;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtpio_state_type;

  rtpio_state_type state_q;
  rtpio_state_type state_d;

  logic [NUM_IN-1:0] raw_in;
  logic [NUM_IN-1:0] clean_in;
  rtpio_remote_type rem;
  rtpio_remote_type fall;
  rtpio_remote_type rise;
  logic [7:0] proc_asserted;

  // every pin passes its own synchroniser and debouncer
  assign raw_in = {remote_i, proc_in_n_i};
  // remote ignore idles low, every other pin idles high
  for (genvar i = 0; i < NUM_IN; i++) begin : g_deb
    rtpio_debounce #(
      .CYCLES(DEB_CYCLES),
      .IDLE((i == NUM_CHAN + 3) ? 1'b0 : PIN_IDLE_RST)
    ) u_deb (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .raw_i(raw_in[i]),
      .level_o(clean_in[i])
    );
  end

  // remote pins in the upper bits, process pins in the low byte
  assign rem = clean_in[NUM_IN-1:NUM_CHAN];
  assign proc_asserted = ~clean_in[NUM_CHAN-1:0];

  // high-to-low is a fall, low-to-high a rise, on clean levels
  assign fall = state_q.prev & ~rem;
  assign rise = ~state_q.prev & rem;

  // command state, register slave and pin drivers in one next-state process
  always_comb begin
    logic aw_have;
    logic w_have;
    logic [7:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic ign;
    aw_have = state_q.aw_held | (s_axi_awvalid & state_q.awready);
    w_have = state_q.w_held | (s_axi_wvalid & state_q.wready);
    aw_a = state_q.aw_held ? state_q.aw_addr : s_axi_awaddr;
    w_d = state_q.w_held ? state_q.w_data : s_axi_wdata;
    w_s = state_q.w_held ? state_q.w_strb : s_axi_wstrb;
    ign = rem.remote_ignore;
    state_d = state_q;
    state_d.prev = rem;

    // gated edge commands: ignored while remote ignore is high
    if (!ign) begin
      if (fall.gauge_a_emit_req_n) state_d.emit_a_req = 1'b1;
      if (rise.gauge_a_emit_req_n) state_d.emit_a_req = 1'b0;
      if (fall.gauge_b_emit_req_n) state_d.emit_b_req = 1'b1;
      if (rise.gauge_b_emit_req_n) state_d.emit_b_req = 1'b0;
      if (fall.bakeout_req_n) state_d.cmd.degas = 1'b1;
      if (rise.bakeout_req_n) state_d.cmd.degas = 1'b0;
      if (fall.filament_a_select_n) state_d.cmd.filament_a_sel = 1'b1;
      if (rise.filament_a_select_n) state_d.cmd.filament_a_sel = 1'b0;
      if (fall.filament_b_select_n) state_d.cmd.filament_b_sel = 1'b1;
      if (rise.filament_b_select_n) state_d.cmd.filament_b_sel = 1'b0;
    end

    // pirani and log edges are not affected by remote ignore
    if (fall.pirani_a_shutdown_n) state_d.cmd.pirani_a_on = 1'b0;
    if (rise.pirani_a_shutdown_n) state_d.cmd.pirani_a_on = 1'b1;
    if (fall.pirani_b_shutdown_n) state_d.cmd.pirani_b_on = 1'b0;
    if (rise.pirani_b_shutdown_n) state_d.cmd.pirani_b_on = 1'b1;
    state_d.cmd.log_clear = fall.log_erase_n; // one-cycle pulse, rise ignored

    // inhibit masks the outputs but keeps the requests, so emission resumes on release
    state_d.cmd.gauge_a_emit = state_d.emit_a_req & rem.emission_inhibit_n;
    state_d.cmd.gauge_b_emit = state_d.emit_b_req & rem.emission_inhibit_n;

    // panel lock covers the gauge keys too
    state_d.cmd.gauge_keys_lock = ~rem.gauge_keys_lock_n | ~rem.panel_lock_n;
    state_d.cmd.panel_lock = ~rem.panel_lock_n;

    // write channel: address and data accepted in either order
    if (s_axi_awvalid && state_q.awready) begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = s_axi_awaddr;
      state_d.awready = 1'b0;
    end
    if (s_axi_wvalid && state_q.wready) begin
      state_d.w_held = 1'b1;
      state_d.w_data = s_axi_wdata;
      state_d.w_strb = s_axi_wstrb;
      state_d.wready = 1'b0;
    end
    if (state_q.bvalid && s_axi_bready) begin
      state_d.bvalid = 1'b0;
      state_d.awready = 1'b1;
      state_d.wready = 1'b1;
    end else if (aw_have && w_have && !state_q.bvalid) begin
      state_d.aw_held = 1'b0;
      state_d.w_held = 1'b0;
      state_d.awready = 1'b0;
      state_d.wready = 1'b0;
      state_d.bvalid = 1'b1;
      if (aw_a[7:2] == REG_CHAN_CTRL[7:2]) begin
        state_d.bresp = RESP_OKAY;
        if (w_s[0]) state_d.chan_active = w_d[7:0];
      end else if (aw_a[7:2] == REG_PROC_IN[7:2] || aw_a[7:2] == REG_REMOTE_IN[7:2]
                   || aw_a[7:2] == REG_CMD_STATE[7:2]) begin
        state_d.bresp = RESP_OKAY; // read-only, write dropped
      end else begin
        state_d.bresp = RESP_SLVERR;
      end
    end

    // read channel: data captured at the address handshake
    if (state_q.rvalid && s_axi_rready) begin
      state_d.rvalid = 1'b0;
      state_d.arready = 1'b1;
    end else if (s_axi_arvalid && state_q.arready) begin
      state_d.arready = 1'b0;
      state_d.rvalid = 1'b1;
      state_d.rresp = RESP_OKAY;
      case (s_axi_araddr[7:2])
        REG_CHAN_CTRL[7:2]: state_d.rdata = {24'h000000, state_q.chan_active};
        REG_PROC_IN[7:2]: state_d.rdata = {24'h000000, proc_asserted};
        REG_REMOTE_IN[7:2]: state_d.rdata = {20'h00000, rem};
        REG_CMD_STATE[7:2]: state_d.rdata = {20'h00000, state_q.emit_b_req, state_q.emit_a_req, state_q.cmd};
        default: begin
          state_d.rdata = 32'h00000000;
          state_d.rresp = RESP_SLVERR;
        end
      endcase
    end

    // process channel pins follow the active mask one cycle later
    state_d.out_n = ~state_q.chan_active; // low while active
    state_d.relay = state_q.chan_active; // 1 = common to normally-open
  end

  // whole state registered in one place
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= '0;
      state_q.prev <= '1;
      state_q.prev.remote_ignore <= 1'b0; // ignore pin idles low
      state_q.cmd.pirani_a_on <= PIRANI_ON_RST;
      state_q.cmd.pirani_b_on <= PIRANI_ON_RST;
      state_q.chan_active <= CHAN_CTRL_RST;
      state_q.out_n <= ~CHAN_CTRL_RST;
      state_q.relay <= CHAN_CTRL_RST;
      state_q.awready <= 1'b1;
      state_q.wready <= 1'b1;
      state_q.arready <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs straight from the state flops
  assign proc_out_n_o = state_q.out_n;
  assign relay_active_o = state_q.relay;
  assign cmd_o = state_q.cmd;
  assign s_axi_awready = state_q.awready;
  assign s_axi_wready = state_q.wready;
  assign s_axi_bresp = state_q.bresp;
  assign s_axi_bvalid = state_q.bvalid;
  assign s_axi_arready = state_q.arready;
  assign s_axi_rdata = state_q.rdata;
  assign s_axi_rresp = state_q.rresp;
  assign s_axi_rvalid = state_q.rvalid;

endmodule : rtpio_top

// ### dv/rtpio_far_model.sv
// far-side process equipment driving the ttl pins
`timescale 1ns/1ps
module rtpio_far_model (
  input wire logic clock_i,
  input wire logic [11:0] lvl_i,
  input wire logic [7:0] act_i,
  output rtpio_pkg::rtpio_remote_type remote_o = 12'hff7,
  output logic [7:0] proc_in_n_o = 8'hff
);
  import rtpio_pkg::*;
  // pins step only just after an edge, never bounce
  always @(posedge clock_i) begin
    remote_o <= rtpio_remote_type'(lvl_i);
    proc_in_n_o <= ~act_i; // active channel pulled low
  end
endmodule : rtpio_far_model

// ### dv/rtpio_top_asserts.sv
// port checks of the remote ttl process i/o block
`timescale 1ns/1ps
module rtpio_checker #(
  parameter int unsigned DEB_CYCLES = 4
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire rtpio_pkg::rtpio_remote_type remote_i,
  input wire logic [7:0] proc_out_n_o,
  input wire logic [7:0] relay_active_o,
  input wire rtpio_pkg::rtpio_cmd_type cmd_o,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  import rtpio_pkg::*;
  logic [7:0] ers_q, inh_q, ign_q;
  default clocking @(posedge clock_i);
  endclocking
  default disable iff (rst_i);
  // held-level run lengths, saturating so long holds never wrap
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ers_q <= 8'h00;
      inh_q <= 8'h00;
      ign_q <= 8'h00;
    end else begin
      ers_q <= remote_i.log_erase_n ? 8'h00 : ers_q + 8'(ers_q != 8'hff);
      inh_q <= remote_i.emission_inhibit_n ? 8'h00 : inh_q + 8'(inh_q != 8'hff);
      ign_q <= !remote_i.remote_ignore ? 8'h00 : ign_q + 8'(ign_q != 8'hff);
    end
  end
  a_relay_mirror: assert property (relay_active_o == ~proc_out_n_o)
    else $error("relay and output disagree");
  a_reset_idle: assert property ($fell(rst_i) |-> proc_out_n_o == 8'hff && cmd_o.pirani_a_on)
    else $error("idle state wrong after reset");
  a_clear_pulse: assert property (cmd_o.log_clear |=> !cmd_o.log_clear)
    else $error("clear pulse too long");
  a_clear_cause: assert property (cmd_o.log_clear |-> ers_q >= DEB_CYCLES)
    else $error("clear without a held fall");
  a_inhibit_off: assert property (inh_q > DEB_CYCLES + 5 |-> !cmd_o.gauge_a_emit && !cmd_o.gauge_b_emit)
    else $error("emission on while inhibited");
  a_ignore_hold: assert property (ign_q > DEB_CYCLES + 5 |=> $stable(cmd_o.degas) && $stable(cmd_o.filament_a_sel))
    else $error("edge acted on while ignored");
  a_panel_keys: assert property (cmd_o.panel_lock |-> cmd_o.gauge_keys_lock)
    else $error("panel lock leaves keys open");
  a_gauge_cause: assert property ($rose(cmd_o.gauge_b_emit) |-> !remote_i.gauge_b_emit_req_n)
    else $error("gauge on without low request");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  c_clear: cover property (cmd_o.log_clear);
  c_inhibit: cover property (inh_q > DEB_CYCLES + 5);
  c_read: cover property (s_axi_rvalid);
endmodule : rtpio_checker

bind rtpio_top rtpio_checker #(.DEB_CYCLES(DEB_CYCLES)) u_chk (.clock_i, .rst_i, .remote_i, .proc_out_n_o,
  .relay_active_o, .cmd_o, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ### dv/test_remote_ttl_process_io.sv
// self-checking bench for the remote ttl process i/o port
`timescale 1ns/1ps
module test_remote_ttl_process_io;
  import rtpio_pkg::*;
  localparam int unsigned DEB = 4;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [11:0] lvl = 12'hff7;
  logic [7:0] act = 8'h00;
  logic [7:0] proc_in_n_i, proc_out_n_o, relay_active_o, s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  rtpio_remote_type remote_i;
  rtpio_cmd_type cmd_o;
  int err_total = 0, checks = 0, clrs = 0;
  int pin_b[7] = '{11, 10, 9, 6, 5, 2, 1};
  int cmd_b[7] = '{9, 8, 7, 6, 5, 4, 3};

  // 100 mhz clock
  always #5 clock_i = ~clock_i;
  rtpio_far_model u_far (.clock_i, .lvl_i(lvl), .act_i(act), .remote_o(remote_i), .proc_in_n_o(proc_in_n_i));
  rtpio_top #(.DEB_CYCLES(DEB)) u_dut (.clock_i, .rst_i, .remote_i, .proc_in_n_i, .proc_out_n_o, .relay_active_o,
    .cmd_o, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  // count clear pulses on the command bus
  always @(posedge clock_i) begin
    if (cmd_o.log_clear === 1'b1) clrs <= clrs + 1;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // pirani commands drop on a falling edge, the rest rise
  function automatic logic fall_exp(input int k);
    return !(cmd_b[k] == 6 || cmd_b[k] == 5);
  endfunction : fall_exp

  // move one pin, then wait past sync and debounce
  task automatic pin(input int b, input logic v);
    lvl[b] <= v;
    repeat (DEB + 10) @(posedge clock_i);
  endtask : pin

  // one register access; valids drop at the edge their ready is seen
  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    do begin
      @(posedge clock_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(wr ? s_axi_bvalid : s_axi_rvalid) && n < 50);
    chk("answer", 32'h1, {31'h0, wr ? s_axi_bvalid : s_axi_rvalid});
    chk("resp", {30'h0, er}, {30'h0, wr ? s_axi_bresp : s_axi_rresp});
    if (!wr) chk("rdata", d, s_axi_rdata);
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge clock_i);
  endtask : axi

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // cut a hang short
  initial begin
    #50us;
    err_total++;
    test_done();
  end

  initial begin
    logic [7:0] m;
    logic [7:0] p;
    int c;
    void'($urandom(50034));
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    chk("out", 32'hff, {24'h0, proc_out_n_o});
    chk("cmd", 32'h060, {22'h0, cmd_o});
    $display("reset test done");
    // full mask first, then random masks
    for (int i = 0; i < 4; i++) begin
      m = (i == 0) ? 8'hff : 8'($urandom);
      axi(1'b1, REG_CHAN_CTRL, {24'h0, m}, RESP_OKAY);
      chk("out", {24'h0, ~m}, {24'h0, proc_out_n_o});
      chk("relay", {24'h0, m}, {24'h0, relay_active_o});
      axi(1'b0, REG_CHAN_CTRL, {24'h0, m}, RESP_OKAY);
    end
    // process inputs, a read-only write and an unmapped place
    p = 8'($urandom);
    act <= p;
    repeat (DEB + 10) @(posedge clock_i);
    axi(1'b0, REG_PROC_IN, {24'h0, p}, RESP_OKAY);
    axi(1'b1, REG_PROC_IN, 32'h0, RESP_OKAY);
    axi(1'b0, REG_PROC_IN, {24'h0, p}, RESP_OKAY);
    axi(1'b0, REG_REMOTE_IN, 32'h00000ff7, RESP_OKAY);
    axi(1'b0, REG_CMD_STATE, 32'h00000060, RESP_OKAY);
    axi(1'b1, 8'h40, 32'h1, RESP_SLVERR);
    axi(1'b0, 8'h40, 32'h0, RESP_SLVERR);
    $display("register test done");
    // every edge command except log erase, fall then rise
    for (int k = 0; k < 7; k++) begin
      pin(pin_b[k], 1'b0);
      chk("fall", 32'(fall_exp(k)), 32'(cmd_o[cmd_b[k]]));
      pin(pin_b[k], 1'b1);
      chk("rise", 32'(!fall_exp(k)), 32'(cmd_o[cmd_b[k]]));
    end
    // inhibit hides a held request, release brings it back
    pin(10, 1'b0);
    pin(8, 1'b0);
    chk("inhibit", 32'h0, 32'(cmd_o.gauge_b_emit));
    pin(8, 1'b1);
    chk("inhibit", 32'h1, 32'(cmd_o.gauge_b_emit));
    pin(10, 1'b1);
    // bakeout edge dropped while ignored
    pin(3, 1'b1);
    pin(9, 1'b0);
    chk("ignore", 32'h0, 32'(cmd_o.degas));
    pin(9, 1'b1);
    pin(3, 1'b0);
    // lock levels follow the pins
    pin(7, 1'b0);
    chk("keys", 32'h1, 32'(cmd_o.gauge_keys_lock));
    pin(0, 1'b0);
    chk("panel", 32'h1, 32'(cmd_o.panel_lock));
    pin(7, 1'b1);
    pin(0, 1'b1);
    chk("keys", 32'h0, 32'(cmd_o.gauge_keys_lock));
    // one clear per fall, none on rise or a short glitch
    c = clrs;
    pin(4, 1'b0);
    pin(4, 1'b1);
    chk("clears", c + 1, clrs);
    lvl[4] <= 1'b0;
    repeat (2) @(posedge clock_i);
    pin(4, 1'b1);
    chk("clears", c + 1, clrs);
    $display("command test done");
    test_done();
  end
endmodule : test_remote_ttl_process_io
